/* File: design/psh_pkg.sv */
// Shared constants and types for the panel status handshake block.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
package psh_pkg;

   // Register byte offsets on the AXI4-Lite bus
   localparam logic [7:0] OFF_CTRL = 8'h00;      // Host control word
   localparam logic [7:0] OFF_NOTIFY = 8'h04;    // Strobe and entry index
   localparam logic [7:0] OFF_STATUS = 8'h08;    // Live panel state
   localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;  // Sticky event bits
   localparam logic [7:0] OFF_IRQ_CLR = 8'h10;   // Write one to clear
   localparam logic [7:0] OFF_IRQ_EN = 8'h14;    // Event enables

   // Control word bit positions
   localparam int unsigned CTRL_DISP = 15;       // Screen shown
   localparam int unsigned CTRL_PRIO = 14;       // Priority request
   localparam int unsigned CTRL_BUZC = 13;       // Continuous buzzer
   localparam int unsigned CTRL_BUZI = 12;       // Intermittent buzzer

   // Notify word layout: BCD index in the low twelve bits
   localparam int unsigned NOTIFY_STROBE = 16;

   // Event bit positions, shared by status, clear and enable
   localparam int unsigned IRQ_ENTRY = 0;        // Number entered
   localparam int unsigned IRQ_BLANK = 1;        // Screen went dark
   localparam int unsigned IRQ_SHOW = 2;         // Screen redisplayed
   localparam int unsigned IRQ_PRIO_LOST = 3;    // Priority taken away
   localparam int unsigned IRQ_W = 4;

   // Values after reset
   localparam logic [15:0] CTRL_RST = 16'h8000;  // Screen on, rest off
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Intermittent buzzer half period
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned BUZ_HALF_MS = 500;
   localparam int unsigned BUZ_HALF_CYC = CLK_HZ / 1000 * BUZ_HALF_MS;

   // Screen state, Gray coded along shown, blank, auto-dark
   typedef enum logic [1:0] {
      SCR_SHOWN = 2'h0,
      SCR_BLANK = 2'h1,
      SCR_AUTODARK = 2'h3
   } psh_scr_t;

   // Panel-side level inputs, carried together
   typedef struct packed {
      logic keyPress;    // Touch key held
      logic entryDone;   // Numeric entry completed
      logic autoDark;    // Local backlight-off timer fired
      logic mode1toN;    // Link set for one host, many panels
      logic prioLost;    // Another panel registered priority later
   } psh_pins_t;

   // Whole state of the top module
   typedef struct packed {
      psh_pins_t [2:0] pinSync;
      logic [2:0][9:0] idxSync;
      psh_pins_t pinF;
      logic [15:0] ctrl;
      logic [15:0] ctrlPrev;
      logic strobe;
      logic [11:0] entryBcd;
      psh_scr_t scr;
      logic prioHeld;
      logic buzCont;
      logic buzInt;
      logic buzPhase;
      logic [23:0] buzCnt;
      logic [IRQ_W-1:0] irqStat;
      logic [IRQ_W-1:0] irqEn;
      logic awHave;
      logic [7:0] awAddr;
      logic wHave;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic awReady;
      logic wReady;
      logic bValid;
      logic [1:0] bResp;
      logic arReady;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic screenOn;
      logic backlightOn;
      logic fastResp;
      logic buzzer;
      logic irq;
   } psh_state_t;

   localparam psh_state_t ST_RST = '{
      ctrl: CTRL_RST, ctrlPrev: CTRL_RST, scr: SCR_SHOWN,
      screenOn: 1'b1, backlightOn: 1'b1, default: '0};

endpackage : psh_pkg

/* File: design/psh_top.sv */
// Panel status handshake: notify word, control word and panel reactions.
// Assumes panel pins are asynchronous levels and software is the host.
// Functional notes
// - Entry completion sets the notify strobe
// - Entry index stored as three BCD digits
// - Strobe clears once host has read it
// - Host control word steers display and service
// - Bit 15 low blanks screen and backlight
// - Bit 15 high or key redisplays after a host blank
// - Bit 14 high gives fast priority response
// - Latest registering panel alone holds priority
// - Priority honoured only on one-to-many link
// - Local changes never rewrite control bits
// - Act on bit changes only, not power-up
// - Bits 13,12 continuous; 12 alone 0.5 s pulsing
`timescale 1ns/1ps
`default_nettype none

module psh_top #(
   parameter int unsigned HALF_SEC_CYC = psh_pkg::BUZ_HALF_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Panel pins
   input wire psh_pkg::psh_pins_t pinsIn,
   input wire logic [9:0] entryIndex,
   // Panel outputs
   output logic screenOn,
   output logic backlightOn,
   output logic fastResp,
   output logic buzzer,
   output logic irq,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // Binary entry number to three BCD digits; values above 999 wrap
   function automatic logic [11:0] toBcd(input logic [9:0] v);
      logic [3:0] d2;
      logic [3:0] d1;
      logic [3:0] d0;
      d2 = 4'((v / 10'd100) % 10'd10);
      d1 = 4'((v / 10'd10) % 10'd10);
      d0 = 4'(v % 10'd10);
      return {d2, d1, d0};
   endfunction : toBcd

   // Byte-lane merge of a bus write into an existing word
   function automatic logic [31:0] wMerge(input logic [31:0] old,
         input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction : wMerge

   // Event vector width, declared before any use below
   localparam int unsigned IRQ_W_L = psh_pkg::IRQ_W;

   psh_pkg::psh_state_t s;            // Registered state
   psh_pkg::psh_state_t n;            // Next state
   psh_pkg::psh_pins_t rise;          // Filtered rising edges this cycle
   logic [15:0] chg;                  // Control bits that changed
   logic [IRQ_W_L-1:0] ev;            // Events raised this cycle
   logic [IRQ_W_L-1:0] clr;           // Software clears this cycle
   logic wrFire;                      // Address and data both held
   logic rdFire;                      // Read address taken
   logic [31:0] rdWord;               // Read mux result
   logic rdOk;                        // Read address is mapped

   // Read multiplexer: unmapped offsets answer zero with an error
   always_comb begin
      rdWord = 32'h0000_0000;
      rdOk = 1'b1;
      case (s_axi_araddr)
         psh_pkg::OFF_CTRL: begin
            rdWord = {16'h0000, s.ctrl};
         end
         psh_pkg::OFF_NOTIFY: begin
            rdWord[psh_pkg::NOTIFY_STROBE] = s.strobe;
            rdWord[11:0] = s.entryBcd;
         end
         psh_pkg::OFF_STATUS: begin
            // Actual state, which may differ from the control word
            rdWord[3:0] = {s.buzzer, s.prioHeld, s.backlightOn,
               s.screenOn};
            rdWord[5:4] = s.scr;
         end
         psh_pkg::OFF_IRQ_STAT: begin
            rdWord[IRQ_W_L-1:0] = s.irqStat;
         end
         psh_pkg::OFF_IRQ_CLR: begin
            // Write-only, reads as zero
            rdWord = 32'h0000_0000;
         end
         psh_pkg::OFF_IRQ_EN: begin
            rdWord[IRQ_W_L-1:0] = s.irqEn;
         end
         default: begin
            rdOk = 1'b0;
         end
      endcase
   end

   // Next-state logic for the whole block
   always_comb begin
      n = s;
      ev = '0;
      clr = '0;

      // Pin synchronisers; stage 0 feeds only stage 1
      n.pinSync = {s.pinSync[1], s.pinSync[0], pinsIn};
      n.idxSync = {s.idxSync[1], s.idxSync[0], entryIndex};
      // A pin changes only once stages 1 and 2 agree
      n.pinF = psh_pkg::psh_pins_t'(
         (s.pinSync[1] & s.pinSync[2]) |
         (s.pinF & (s.pinSync[1] | s.pinSync[2])));
      rise = psh_pkg::psh_pins_t'(n.pinF & ~s.pinF);

      // Bus write: address and data latch independently, in any order
      wrFire = s.awHave && s.wHave && !s.bValid;
      if (s_axi_awvalid && s.awReady) begin
         n.awHave = 1'b1;
         n.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wReady) begin
         n.wHave = 1'b1;
         n.wData = s_axi_wdata;
         n.wStrb = s_axi_wstrb;
      end
      if (s.bValid && s_axi_bready) begin
         n.bValid = 1'b0;
      end
      if (wrFire) begin
         n.awHave = 1'b0;
         n.wHave = 1'b0;
         n.bValid = 1'b1;
         n.bResp = psh_pkg::RESP_OKAY;
         case (s.awAddr)
            psh_pkg::OFF_CTRL: begin
               // Host owns this word; panel logic never writes it
               n.ctrl = 16'(wMerge({16'h0000, s.ctrl}, s.wData,
                  s.wStrb));
            end
            psh_pkg::OFF_IRQ_CLR: begin
               if (s.wStrb[0]) begin
                  clr = s.wData[IRQ_W_L-1:0];
               end
            end
            psh_pkg::OFF_IRQ_EN: begin
               n.irqEn = IRQ_W_L'(wMerge({28'h000_0000, s.irqEn},
                  s.wData, s.wStrb));
            end
            psh_pkg::OFF_NOTIFY, psh_pkg::OFF_STATUS,
            psh_pkg::OFF_IRQ_STAT: begin
               // Read-only words ignore writes
               n.bResp = psh_pkg::RESP_OKAY;
            end
            default: begin
               n.bResp = psh_pkg::RESP_SLVERR;
            end
         endcase
      end
      n.awReady = !n.awHave;
      n.wReady = !n.wHave;

      // Bus read: one outstanding, data captured when address taken
      rdFire = s_axi_arvalid && s.arReady;
      if (s.rValid && s_axi_rready) begin
         n.rValid = 1'b0;
      end
      if (rdFire) begin
         n.rValid = 1'b1;
         n.rData = rdWord;
         n.rResp = rdOk ? psh_pkg::RESP_OKAY : psh_pkg::RESP_SLVERR;
      end
      n.arReady = !n.rValid;

      // Strobe drops once the host has read the notify word
      if (rdFire && s_axi_araddr == psh_pkg::OFF_NOTIFY) begin
         n.strobe = 1'b0;
      end
      // A new entry wins over a clear in the same cycle
      if (rise.entryDone) begin
         n.strobe = 1'b1;
         // Index lands on the same edge as the strobe
         n.entryBcd = toBcd(s.idxSync[2]);
         ev[psh_pkg::IRQ_ENTRY] = 1'b1;
      end

      // Control word acts on changes only; reset value equals prev
      chg = s.ctrl ^ s.ctrlPrev;
      n.ctrlPrev = s.ctrl;

      // Screen state machine
      case (s.scr)
         psh_pkg::SCR_SHOWN: begin
            if (chg[psh_pkg::CTRL_DISP] && !s.ctrl[psh_pkg::CTRL_DISP])
            begin
               n.scr = psh_pkg::SCR_BLANK;
               ev[psh_pkg::IRQ_BLANK] = 1'b1;
            end else if (rise.autoDark) begin
               // Local timer darkens without touching control bits
               n.scr = psh_pkg::SCR_AUTODARK;
               ev[psh_pkg::IRQ_BLANK] = 1'b1;
            end
         end
         psh_pkg::SCR_BLANK: begin
            if ((chg[psh_pkg::CTRL_DISP] && s.ctrl[psh_pkg::CTRL_DISP])
                  || rise.keyPress) begin
               n.scr = psh_pkg::SCR_SHOWN;
               ev[psh_pkg::IRQ_SHOW] = 1'b1;
            end
         end
         psh_pkg::SCR_AUTODARK: begin
            // Only a host bit 15 fall leaves it, moving to blank
            if (chg[psh_pkg::CTRL_DISP] && !s.ctrl[psh_pkg::CTRL_DISP])
            begin
               n.scr = psh_pkg::SCR_BLANK;
            end
         end
         default: begin
            n.scr = psh_pkg::SCR_SHOWN;
         end
      endcase

      // Priority service, only on a one-host-to-many-panels link
      if (!s.pinF.mode1toN) begin
         n.prioHeld = 1'b0;
      end else if (chg[psh_pkg::CTRL_PRIO]) begin
         // Our own fresh request is the latest, so it wins
         n.prioHeld = s.ctrl[psh_pkg::CTRL_PRIO];
      end else if (rise.prioLost && s.prioHeld) begin
         n.prioHeld = 1'b0;
         ev[psh_pkg::IRQ_PRIO_LOST] = 1'b1;
      end

      // Buzzer mode latched on change; continuous has precedence
      if (chg[psh_pkg::CTRL_BUZC] || chg[psh_pkg::CTRL_BUZI]) begin
         n.buzCont = s.ctrl[psh_pkg::CTRL_BUZC];
         n.buzInt = s.ctrl[psh_pkg::CTRL_BUZI] &&
            !s.ctrl[psh_pkg::CTRL_BUZC];
         n.buzPhase = 1'b1;
         n.buzCnt = '0;
      end else if (s.buzInt) begin
         // Half-second on, half-second off
         if (s.buzCnt == 24'(HALF_SEC_CYC - 1)) begin
            n.buzCnt = '0;
            n.buzPhase = !s.buzPhase;
         end else begin
            n.buzCnt = s.buzCnt + 24'h00_0001;
         end
      end

      // Sticky events: a set wins over a clear in the same cycle
      n.irqStat = (s.irqStat & ~clr) | ev;

      // Registered outputs
      n.screenOn = (n.scr == psh_pkg::SCR_SHOWN);
      n.backlightOn = (n.scr == psh_pkg::SCR_SHOWN);
      n.fastResp = n.prioHeld;
      n.buzzer = n.buzCont || (n.buzInt && n.buzPhase);
      n.irq = |(n.irqStat & n.irqEn);
   end

   // State register with synchronous reset
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s <= psh_pkg::ST_RST;
      end else begin
         s <= n;
      end
   end

   // Outputs straight from flops
   assign screenOn = s.screenOn;
   assign backlightOn = s.backlightOn;
   assign fastResp = s.fastResp;
   assign buzzer = s.buzzer;
   assign irq = s.irq;
   assign s_axi_awready = s.awReady;
   assign s_axi_wready = s.wReady;
   assign s_axi_bvalid = s.bValid;
   assign s_axi_bresp = s.bResp;
   assign s_axi_arready = s.arReady;
   assign s_axi_rvalid = s.rValid;
   assign s_axi_rdata = s.rData;
   assign s_axi_rresp = s.rResp;

endmodule : psh_top

`default_nettype wire

/* File: verif/psh_panel_model.sv */
// Panel-side model: touch key, entry completion and link-mode pins.
// Assumes the bench calls its tasks; pins change just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module psh_panel_model (
   // Clock
   input wire logic clk_sys,
   // Pins towards the block
   output var psh_pkg::psh_pins_t pins,
   output var logic [9:0] entryIndex
);
   // Quiet pins at time zero
   initial begin
      pins = '0;
      entryIndex = 10'h000;
   end
   // Index settles well before the completion edge, as the filter needs
   task automatic enter(input logic [9:0] idx);
      @(posedge clk_sys) entryIndex <= idx;
      repeat (5) @(posedge clk_sys);
      pins.entryDone <= 1'b1;
      repeat (6) @(posedge clk_sys);
      pins.entryDone <= 1'b0;
      entryIndex <= ~idx; // Index no longer held, so show a wrong one
   endtask : enter
   // Four cycles clears the three-stage filter with margin
   // k is the pin's bit position: 4 key, 2 auto-dark, 0 priority lost
   task automatic pulse(input int k);
      @(posedge clk_sys);
      case (k)
         4: pins.keyPress <= 1'b1;
         2: pins.autoDark <= 1'b1;
         default: pins.prioLost <= 1'b1;
      endcase
      repeat (4) @(posedge clk_sys);
      // Only one of these was raised; dropping all is harmless
      pins.keyPress <= 1'b0;
      pins.autoDark <= 1'b0;
      pins.prioLost <= 1'b0;
   endtask : pulse
   // Link mode is a level
   task automatic set_mode(input logic m);
      @(posedge clk_sys) pins.mode1toN <= m;
   endtask : set_mode
endmodule : psh_panel_model
`default_nettype wire

/* File: verif/psh_top_asserts.sv */
// Checker for the panel status handshake top: reactions and write path.
// Assumes the bus master writes whole words, one write at a time.
`timescale 1ns/1ps
`default_nettype none
module psh_top_asserts #(
   parameter int unsigned HALF_SEC_CYC = psh_pkg::BUZ_HALF_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Panel side
   input wire psh_pkg::psh_pins_t pinsIn,
   input wire logic screenOn,
   input wire logic backlightOn,
   input wire logic fastResp,
   input wire logic buzzer,
   // Write path
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic [7:0] addr_q; // Address of the write under way
   logic [15:0] data_q; // Its data
   logic [15:0] ctrl_q; // Control word as last written
   logic [23:0] hiCnt_q; // Length of the current buzzer-on run
   // Track the write; the control copy moves when the answer appears
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         addr_q <= 8'h00;
         data_q <= 16'h0000;
         ctrl_q <= psh_pkg::CTRL_RST;
         hiCnt_q <= 24'h00_0000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) addr_q <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) data_q <= s_axi_wdata[15:0];
         if ($rose(s_axi_bvalid) && addr_q == psh_pkg::OFF_CTRL) begin
            ctrl_q <= data_q;
         end
         hiCnt_q <= buzzer ? hiCnt_q + 24'h00_0001 : 24'h00_0000;
      end
   end
   // A control bit changes from one value to the other
   sequence ctrl_bit(int b, bit from, bit to);
      $rose(s_axi_bvalid) && addr_q == psh_pkg::OFF_CTRL &&
         ctrl_q[b] == from && data_q[b] == to;
   endsequence
   a_light_follows: assert property (backlightOn == screenOn)
      else $error("backlight differs from screen");
   a_blank_on_fall: assert property (
      ctrl_bit(15, 1, 0) |-> ##[1:3] !screenOn)
      else $error("screen not blanked");
   a_show_on_rise: assert property (
      ctrl_bit(15, 0, 1) |-> ##[1:3] screenOn)
      else $error("screen not redisplayed");
   a_prio_drop: assert property (
      ctrl_bit(14, 1, 0) |-> ##[1:3] !fastResp)
      else $error("priority kept after release");
   a_mode_gate: assert property (
      !pinsIn.mode1toN [*8] |-> !fastResp)
      else $error("priority outside one-to-many mode");
   a_buzz_quiet: assert property (
      (!ctrl_q[13] && !ctrl_q[12]) [*4] |-> !buzzer)
      else $error("buzzer sounds while off");
   a_buzz_half: assert property ($fell(buzzer) && ctrl_q[12] && !ctrl_q[13]
      |-> hiCnt_q == HALF_SEC_CYC)
      else $error("intermittent on time wrong");
   a_bresp_map: assert property (s_axi_bvalid |-> s_axi_bresp ==
      ((addr_q <= psh_pkg::OFF_IRQ_EN && addr_q[1:0] == 2'h0) ?
      psh_pkg::RESP_OKAY : psh_pkg::RESP_SLVERR))
      else $error("write response wrong");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
endmodule : psh_top_asserts
bind psh_top psh_top_asserts #(.HALF_SEC_CYC(HALF_SEC_CYC)) u_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .pinsIn(pinsIn),
   .screenOn(screenOn), .backlightOn(backlightOn), .fastResp(fastResp),
   .buzzer(buzzer), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
`default_nettype wire

/* File: verif/psh_top_tb.sv */
// Bench for the panel status handshake block: AXI4-Lite host and panel.
// Assumes a 20 MHz clock and a shortened buzzer half period.
`timescale 1ns/1ps
`default_nettype none
module psh_top_tb;
   localparam int unsigned HALF = 8; // Short half period keeps runs brief
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [31:0] s_axi_rdata, rdd;
   logic screenOn, backlightOn, fastResp, buzzer, irq;
   psh_pkg::psh_pins_t pins;
   logic [9:0] entryIndex;
   // Outputs as one vector so waits share a task
   wire logic [4:0] outs = {irq, buzzer, fastResp, backlightOn, screenOn};
   int mismatches = 0, checks_done = 0;
   always #25 clk_sys = ~clk_sys;
   psh_top #(.HALF_SEC_CYC(HALF)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .pinsIn(pins), .entryIndex(entryIndex), .screenOn(screenOn),
      .backlightOn(backlightOn), .fastResp(fastResp), .buzzer(buzzer),
      .irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   psh_panel_model panel (.clk_sys(clk_sys), .pins(pins),
      .entryIndex(entryIndex));
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic give_up();
      mismatches++;
      report_and_stop();
   endtask : give_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask : chk
   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      if (n >= 100) give_up();
      s_axi_bready <= 1'b0;
      rs = s_axi_bresp;
   endtask : wr
   // Read: result taken at the edge that sees rvalid
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      if (n >= 100) give_up();
      s_axi_rready <= 1'b0;
      rdd = s_axi_rdata;
      rs = s_axi_rresp;
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rdd, e);
   endtask : rchk
   // Bounded wait for an output level; running out ends the run
   task automatic wait_out(input int k, input logic v, input int n);
      for (int i = 0; i < n && outs[k] !== v; i++) @(posedge clk_sys);
      chk(outs[k], v);
      if (outs[k] !== v) give_up();
   endtask : wait_out
   task automatic stay_out(input int k, input logic v, input int n);
      repeat (n) begin
         @(posedge clk_sys);
         chk(outs[k], v);
      end
   endtask : stay_out
   task automatic t_reset();
      stay_out(0, 1'b1, 4);
      rchk(psh_pkg::OFF_CTRL, 32'h0000_8000);
      rchk(8'h20, 32'h0000_0000);
      chk(rs, psh_pkg::RESP_SLVERR);
      wr(8'h20, 32'h0000_0001);
      chk(rs, psh_pkg::RESP_SLVERR);
      $display("reset test done");
   endtask : t_reset
   task automatic t_entry();
      wr(psh_pkg::OFF_IRQ_EN, 32'h0000_0001);
      // Lane 1 only: the enable bits in lane 0 must survive
      s_axi_wstrb <= 4'h2;
      wr(psh_pkg::OFF_IRQ_EN, 32'h0000_0000);
      s_axi_wstrb <= 4'hF;
      rchk(psh_pkg::OFF_IRQ_EN, 32'h0000_0001);
      panel.enter(10'h1D8);
      wait_out(4, 1'b1, 12);
      rchk(psh_pkg::OFF_NOTIFY, 32'h0001_0472);
      rchk(psh_pkg::OFF_NOTIFY, 32'h0000_0472);
      wr(psh_pkg::OFF_IRQ_CLR, 32'h0000_0001);
      wait_out(4, 1'b0, 8);
      wr(psh_pkg::OFF_IRQ_EN, 32'h0000_0000);
      panel.enter(10'h3E7);
      stay_out(4, 1'b0, 4);
      rchk(psh_pkg::OFF_IRQ_STAT, 32'h0000_0001);
      rchk(psh_pkg::OFF_NOTIFY, 32'h0001_0999);
      wr(psh_pkg::OFF_IRQ_CLR, 32'h0000_0001);
      $display("entry test done");
   endtask : t_entry
   task automatic t_screen();
      wr(psh_pkg::OFF_CTRL, 32'h0000_0000);
      wait_out(0, 1'b0, 10);
      chk(outs[1], 1'b0);
      panel.pulse(4);
      wait_out(0, 1'b1, 12);
      rchk(psh_pkg::OFF_CTRL, 32'h0000_0000);
      wr(psh_pkg::OFF_CTRL, 32'h0000_8000);
      wr(psh_pkg::OFF_CTRL, 32'h0000_0000);
      wait_out(0, 1'b0, 10);
      wr(psh_pkg::OFF_CTRL, 32'h0000_8000);
      wait_out(0, 1'b1, 10);
      panel.pulse(2);
      wait_out(0, 1'b0, 12);
      panel.pulse(4);
      stay_out(0, 1'b0, 12);
      wr(psh_pkg::OFF_CTRL, 32'h0000_8000);
      stay_out(0, 1'b0, 8);
      wr(psh_pkg::OFF_CTRL, 32'h0000_0000);
      wr(psh_pkg::OFF_CTRL, 32'h0000_8000);
      wait_out(0, 1'b1, 10);
      $display("screen test done");
   endtask : t_screen
   task automatic t_prio();
      wr(psh_pkg::OFF_CTRL, 32'h0000_C000);
      stay_out(2, 1'b0, 10);
      wr(psh_pkg::OFF_CTRL, 32'h0000_8000);
      panel.set_mode(1'b1);
      repeat (6) @(posedge clk_sys);
      wr(psh_pkg::OFF_CTRL, 32'h0000_C000);
      wait_out(2, 1'b1, 10);
      panel.pulse(0);
      wait_out(2, 1'b0, 12);
      wr(psh_pkg::OFF_CTRL, 32'h0000_8000);
      wr(psh_pkg::OFF_CTRL, 32'h0000_C000);
      wait_out(2, 1'b1, 10);
      wr(psh_pkg::OFF_CTRL, 32'h0000_8000);
      wait_out(2, 1'b0, 10);
      $display("priority test done");
   endtask : t_prio
   task automatic t_buzz();
      int i;
      wr(psh_pkg::OFF_CTRL, 32'h0000_9000);
      wait_out(3, 1'b1, 20);
      for (i = 0; i < 20 && outs[3] === 1'b1; i++) @(posedge clk_sys);
      chk(i, HALF);
      wr(psh_pkg::OFF_CTRL, 32'h0000_B000);
      wait_out(3, 1'b1, 20);
      stay_out(3, 1'b1, 20);
      wr(psh_pkg::OFF_CTRL, 32'h0000_8000);
      wait_out(3, 1'b0, 10);
      $display("buzzer test done");
   endtask : t_buzz
   // Main sequence
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset();
      t_entry();
      t_screen();
      t_prio();
      t_buzz();
      report_and_stop();
   end
endmodule : psh_top_tb
`default_nettype wire
